// ---- host_port_pkg.sv ----
package host_port_pkg;

    localparam int ADDR_W      = 14;
    localparam int DATA_W      = 8;
    localparam int CTRL_W      = 16;
    localparam int STRAP_CPOL  = 7;
    localparam int STRAP_CPHA  = 6;
    localparam int STRAP_SWAP  = 5;
    localparam logic [3:0] CTRL_LAST = 4'hf;
    localparam logic [3:0] DATA_LAST = 4'h7;
    localparam logic [2:0] STRAP_RST = 3'h0;

    // pins that cross into the ref_clk domain together
    typedef struct packed {
        logic                cs_n;
        logic                rd_n;
        logic                wr_n;
        logic                dir_n;
        logic                ds_n;
        logic                style;
        logic                ser_sel;
        logic                sclk;
        logic                mosi;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } pins_t;

    // synchroniser reset levels: strobes and chip select idle high, no false edge
    localparam pins_t PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, dir_n: 1'b1,
                                    ds_n: 1'b1, style: 1'b0, ser_sel: 1'b0, sclk: 1'b0,
                                    mosi: 1'b1, addr: '0, data: '0};

    // one request towards the register core
    typedef struct packed {
        logic                rd;
        logic                wr;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } core_req_t;

    typedef enum logic {
        SER_CTRL,
        SER_DATA
    } ser_state_t;

endpackage

// ---- sync_two.sv ----
`timescale 1ns/100ps
`default_nettype none
module sync_two #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         ref_clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // two flops, the first read only by the second; reset to the pin idle level
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q   <= INIT;
            sync_out <= INIT;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ---- host_processor_port.sv ----
`timescale 1ns/100ps
`default_nettype none
module host_processor_port (
    input  wire logic                             ref_clk,
    input  wire logic                             reset_n,
    input  wire logic                             bus_style_select,
    input  wire logic                             serial_select,
    input  wire logic                             chip_select_n,
    input  wire logic                             read_strobe_n,
    input  wire logic                             write_strobe_n,
    input  wire logic                             direction_n,
    input  wire logic                             data_strobe_n,
    input  wire logic [host_port_pkg::ADDR_W-1:0] addr,
    input  wire logic [host_port_pkg::DATA_W-1:0] data_in,
    output logic      [host_port_pkg::DATA_W-1:0] data_out,
    output logic                                  data_oe,
    input  wire logic                             serial_clk,
    input  wire logic                             serial_mosi,
    output logic                                  serial_miso,
    output logic                                  serial_miso_oe,
    output logic                                  interrupt_n_out,
    output logic                                  interrupt_n_oe,
    input  wire logic                             irq_pending,
    output host_port_pkg::core_req_t              core_req,
    input  wire logic [host_port_pkg::DATA_W-1:0] core_rdata
);
    host_port_pkg::pins_t      pins_raw;
    host_port_pkg::pins_t      pins_s;
    host_port_pkg::core_req_t  req_d;
    host_port_pkg::ser_state_t ser_state_q;
    host_port_pkg::ser_state_t ser_state_d;

    logic [2:0]                         strap_q;
    logic                               par_rd_q;
    logic                               par_wr_q;
    logic [host_port_pkg::DATA_W-1:0]   par_wdata_q;
    logic [host_port_pkg::ADDR_W-1:0]   par_addr_q;
    logic                               sclk_prev_q;
    logic [3:0]                         cnt_q;
    logic [host_port_pkg::CTRL_W-1:0]   sh_q;
    logic                               rw_q;
    logic                               burst_q;
    logic [host_port_pkg::ADDR_W-1:0]   saddr_q;
    logic [host_port_pkg::ADDR_W-1:0]   saddr_d;
    logic [host_port_pkg::DATA_W-1:0]   tx_q;
    logic                               pend_q;
    logic                               pend2_q;
    logic                               drive_q;

    function automatic logic [host_port_pkg::DATA_W-1:0] rev8(
        input logic [host_port_pkg::DATA_W-1:0] v);
        for (int i = 0; i < host_port_pkg::DATA_W; i++) begin
            rev8[i] = v[host_port_pkg::DATA_W-1-i];
        end
    endfunction

    function automatic logic [host_port_pkg::ADDR_W-1:0] rev14(
        input logic [host_port_pkg::ADDR_W-1:0] v);
        for (int i = 0; i < host_port_pkg::ADDR_W; i++) begin
            rev14[i] = v[host_port_pkg::ADDR_W-1-i];
        end
    endfunction

    // every pin passes two flops before use
    assign pins_raw = '{cs_n: chip_select_n, rd_n: read_strobe_n, wr_n: write_strobe_n,
                        dir_n: direction_n, ds_n: data_strobe_n, style: bus_style_select,
                        ser_sel: serial_select, sclk: serial_clk, mosi: serial_mosi,
                        addr: addr, data: data_in};

    sync_two #(.W($bits(host_port_pkg::pins_t)), .INIT(host_port_pkg::PINS_IDLE)) u_sync (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .async_in (pins_raw),
        .sync_out (pins_s)
    );

    // parallel strobe decode, both styles
    wire cs_act     = !pins_s.cs_n && !pins_s.ser_sel;
    wire rd_style0  = !pins_s.rd_n;
    wire wr_style0  = !pins_s.wr_n;
    wire rd_style1  = !pins_s.ds_n && pins_s.dir_n;
    wire wr_style1  = !pins_s.ds_n && !pins_s.dir_n;
    wire par_rd_act = cs_act && (pins_s.style ? rd_style1 : rd_style0);
    wire par_wr_act = cs_act && (pins_s.style ? wr_style1 : wr_style0);
    wire par_rd_go  = par_rd_act && !par_rd_q;
    wire par_wr_end = !par_wr_act && par_wr_q;

    // straps: cpol, cpha, swap from data pins
    wire cpol = strap_q[2];
    wire cpha = strap_q[1];
    wire swap = strap_q[0];

    // serial clock edges relative to the idle level
    wire ser_on   = pins_s.ser_sel && !pins_s.cs_n;
    wire leading  = ser_on && (pins_s.sclk != cpol) && (sclk_prev_q == cpol);
    wire trailing = ser_on && (pins_s.sclk == cpol) && (sclk_prev_q != cpol);
    wire samp_ev  = cpha ? trailing : leading;
    wire launch_ev = cpha ? leading : trailing;

    // received words and decoded fields
    wire [host_port_pkg::CTRL_W-1:0] ctrl_w = {sh_q[host_port_pkg::CTRL_W-2:0], pins_s.mosi};
    wire [host_port_pkg::DATA_W-1:0] byte_w = {sh_q[host_port_pkg::DATA_W-2:0], pins_s.mosi};
    wire [host_port_pkg::ADDR_W-1:0] ctrl_a = ctrl_w[host_port_pkg::CTRL_W-2:1];
    wire [host_port_pkg::ADDR_W-1:0] ctrl_addr = swap ? rev14(ctrl_a) : ctrl_a;
    wire [host_port_pkg::DATA_W-1:0] rx_data = swap ? rev8(byte_w) : byte_w;
    wire ctrl_done = samp_ev && ser_state_q == host_port_pkg::SER_CTRL
                     && cnt_q == host_port_pkg::CTRL_LAST;
    wire data_done = samp_ev && ser_state_q == host_port_pkg::SER_DATA
                     && cnt_q == host_port_pkg::DATA_LAST;
    wire ctrl_rw   = ctrl_w[host_port_pkg::CTRL_W-1];
    wire ctrl_bst  = ctrl_w[0];
    wire ser_rd_go = (ctrl_done && ctrl_rw) || (data_done && rw_q && burst_q);
    wire ser_wr_go = data_done && !rw_q;
    wire [host_port_pkg::ADDR_W-1:0] saddr_inc = saddr_q + 14'h0001;

    // next serial address: from control, or stepped in a burst
    assign saddr_d = ctrl_done ? ctrl_addr
                   : (data_done && burst_q) ? saddr_inc : saddr_q;

    // next serial state
    always_comb begin
        ser_state_d = ser_state_q;
        unique case (ser_state_q)
            host_port_pkg::SER_CTRL: begin
                if (ctrl_done) begin
                    ser_state_d = host_port_pkg::SER_DATA;
                end
            end
            host_port_pkg::SER_DATA: begin
                if (data_done && !burst_q) begin
                    ser_state_d = host_port_pkg::SER_CTRL;
                end
            end
        endcase
    end

    // request towards the core, parallel or serial
    assign req_d.rd    = par_rd_go || ser_rd_go;
    assign req_d.wr    = par_wr_end || ser_wr_go;
    assign req_d.addr  = pins_s.ser_sel ? (ser_wr_go ? saddr_q : saddr_d)
                                        : (par_wr_end ? par_addr_q : pins_s.addr);
    assign req_d.wdata = pins_s.ser_sel ? rx_data : par_wdata_q;

    // strap capture while the serial port is idle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_q <= host_port_pkg::STRAP_RST;
        end else if (pins_s.ser_sel && pins_s.cs_n) begin
            strap_q <= {pins_s.data[host_port_pkg::STRAP_CPOL],
                        pins_s.data[host_port_pkg::STRAP_CPHA],
                        pins_s.data[host_port_pkg::STRAP_SWAP]};
        end
    end

    // parallel port: strobe history, held address and write data
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            par_rd_q    <= 1'b0;
            par_wr_q    <= 1'b0;
            par_wdata_q <= '0;
            par_addr_q  <= '0;
        end else begin
            par_rd_q <= par_rd_act;
            par_wr_q <= par_wr_act;
            if (par_wr_act) begin
                par_wdata_q <= pins_s.data;
                par_addr_q  <= pins_s.addr;
            end
        end
    end

    // parallel read data drive and core request
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_out <= '0;
            data_oe  <= 1'b0;
            core_req <= '0;
        end else begin
            data_out <= core_rdata;
            data_oe  <= par_rd_act;
            core_req <= req_d;
        end
    end

    // serial receive: state, bit count, shift, control fields
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_prev_q <= 1'b0;
            ser_state_q <= host_port_pkg::SER_CTRL;
            cnt_q       <= 4'h0;
            sh_q        <= '0;
            rw_q        <= 1'b0;
            burst_q     <= 1'b0;
            saddr_q     <= '0;
        end else begin
            sclk_prev_q <= pins_s.sclk;
            if (pins_s.cs_n) begin
                ser_state_q <= host_port_pkg::SER_CTRL;
                cnt_q       <= 4'h0;
                burst_q     <= 1'b0;
            end else if (samp_ev) begin
                ser_state_q <= ser_state_d;
                sh_q        <= ctrl_w;
                saddr_q     <= saddr_d;
                cnt_q       <= (ctrl_done || data_done) ? 4'h0 : cnt_q + 4'h1;
                if (ctrl_done) begin
                    rw_q    <= ctrl_rw;
                    burst_q <= ctrl_bst;
                end
            end
        end
    end

    // serial transmit: load read data, shift out on launch edges
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_q         <= 1'b0;
            pend2_q        <= 1'b0;
            tx_q           <= '0;
            serial_miso    <= 1'b1;
            serial_miso_oe <= 1'b0;
        end else begin
            pend_q  <= ser_rd_go;
            pend2_q <= pend_q;
            if (pend2_q) begin
                tx_q <= swap ? rev8(core_rdata) : core_rdata;
            end else if (launch_ev && ser_state_q == host_port_pkg::SER_DATA) begin
                serial_miso <= tx_q[host_port_pkg::DATA_W-1];
                tx_q        <= {tx_q[host_port_pkg::DATA_W-2:0], 1'b0};
            end
            serial_miso_oe <= ser_on && rw_q
                              && ser_state_q == host_port_pkg::SER_DATA;
        end
    end

    // open-drain interrupt: low level, enabled while pending
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            drive_q        <= 1'b0;
            interrupt_n_oe <= 1'b0;
        end else begin
            drive_q        <= 1'b0;
            interrupt_n_oe <= irq_pending;
        end
    end
    assign interrupt_n_out = drive_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_par_oe_cs: assert property (data_oe |-> $past(cs_act) && !$past(pins_s.ser_sel))
        else $error("data bus driven without chip select or in serial mode");
    a_par_wr_pulse: assert property (par_wr_end |=> core_req.wr && !core_req.rd)
        else $error("end of write strobe gave no write request");
    a_style_read: assert property (cs_act && pins_s.style && !pins_s.ds_n && pins_s.dir_n
                                   |=> data_oe)
        else $error("direction style read not driven");
    a_irq_follow: assert property (irq_pending |=> interrupt_n_oe ##0 !interrupt_n_out)
        else $error("interrupt not asserted low");
    a_irq_release: assert property (!irq_pending |=> !interrupt_n_oe)
        else $error("interrupt held without cause");
    a_cs_ends_burst: assert property ($rose(pins_s.cs_n) |=> ser_state_q == host_port_pkg::SER_CTRL
                                      && cnt_q == 4'h0 && !burst_q)
        else $error("chip select release did not end access");
    a_ctrl_to_data: assert property (ctrl_done && !pins_s.cs_n
                                     |=> ser_state_q == host_port_pkg::SER_DATA)
        else $error("control word did not open data phase");
    a_burst_step: assert property (data_done && burst_q && !pins_s.cs_n
                                   |=> saddr_q == $past(saddr_inc)
                                   && ser_state_q == host_port_pkg::SER_DATA)
        else $error("burst address did not step");
    a_no_burst_ctrl: assert property (data_done && !burst_q && !pins_s.cs_n
                                      |=> ser_state_q == host_port_pkg::SER_CTRL)
        else $error("control expected after non-burst data");
    a_miso_window: assert property (serial_miso_oe |-> $past(ser_on) && $past(rw_q))
        else $error("serial output driven outside read data phase");
    a_read_load: assert property (ser_rd_go |=> core_req.rd ##2 tx_q == (swap ? rev8($past(core_rdata))
                                  : $past(core_rdata)))
        else $error("serial read data not loaded");

    // request, strap and serial output checks
    a_par_rd_req: assert property (par_rd_go && !par_wr_end |=> core_req.rd && data_oe
                                   && core_req.addr == $past(pins_s.addr))
        else $error("parallel read start gave no read request");
    a_sel_quiet: assert property (!cs_act && !ser_on && !par_wr_q
                                  |=> !core_req.rd && !core_req.wr)
        else $error("request raised with the port deselected");
    a_strap_frozen: assert property (!pins_s.cs_n |=> $stable(strap_q))
        else $error("strap settings changed under chip select");
    a_ser_wr_req: assert property (ser_wr_go |=> core_req.wr
                                   && core_req.addr == $past(saddr_q)
                                   && core_req.wdata == $past(rx_data))
        else $error("serial data byte gave no matching write");
    a_burst_read: assert property (data_done && rw_q && burst_q
                                   |=> core_req.rd && core_req.addr == $past(saddr_inc))
        else $error("burst read did not fetch the next address");
    a_miso_idle: assert property (pins_s.cs_n |=> !serial_miso_oe)
        else $error("serial output driven while deselected");

    c_serial_write: cover property (ser_wr_go);
    c_serial_burst: cover property (data_done && burst_q ##[1:200] data_done);
    c_par_read: cover property (par_rd_go ##[1:20] !par_rd_act);
    c_par_write_s1: cover property (par_wr_end && pins_s.style);
    c_ser_read_ph1: cover property (ser_rd_go && cpha);
endmodule
`default_nettype wire

// ---- serial_master.sv ----
`timescale 1ns/100ps
`default_nettype none
module serial_master (
    input  wire logic ref_clk,
    input  wire logic cpol,
    input  wire logic cpha,
    input  wire logic miso,
    input  wire logic miso_oe,
    output logic      sclk,
    output logic      mosi,
    output logic      cs_n
);
    // link idles with select high and clock parked
    initial begin
        sclk = 1'b0;
        mosi = 1'b1;
        cs_n = 1'b1;
    end

    // half period of the 160 ns link clock
    task automatic half();
        repeat (8) @(negedge ref_clk);
    endtask

    // park clock at idle level, then assert select
    task automatic open_frame();
        sclk = cpol;
        half();
        cs_n = 1'b0;
        half();
    endtask

    // drop select; a released data line shows the inverse of its last value
    task automatic close_frame();
        half();
        cs_n = 1'b1;
        mosi = ~mosi;
        half();
    endtask

    // one byte msb first on the wire; an undriven miso reads as z
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            if (!cpha) mosi = tx[i];
            half();
            sclk = ~cpol;
            if (cpha) mosi = tx[i];
            else rx[i] = miso_oe ? miso : 1'bz;
            half();
            if (cpha) rx[i] = miso_oe ? miso : 1'bz;
            sclk = cpol;
        end
    endtask
endmodule
`default_nettype wire

// ---- host_processor_port_test.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module host_processor_port_test;
    logic ref_clk = 1'b0, reset_n = 1'b0, style = 1'b0, ser_sel = 1'b0, p_cs_n = 1'b1;
    logic rd_n = 1'b1, wr_n = 1'b1, dir_n = 1'b1, ds_n = 1'b1, irq = 1'b0;
    logic cpol = 1'b0, cpha = 1'b0, swap = 1'b0;
    logic [13:0] addr = 14'h0000, last_rd_q = 14'h0000, rd_addr, wr_addr;
    logic [7:0] bus_drv = 8'h00, data_bus, data_out, core_rdata, wr_data;
    logic data_oe, m_sclk, m_mosi, m_cs_n, miso, miso_oe, int_out, int_oe;
    host_port_pkg::core_req_t core_req;
    int num_errors = 0, tests_run = 0, wr_cnt = 0, rd_cnt = 0, cycles = 0;

    always #5 ref_clk = ~ref_clk;

    // two-way data pins and the shared select pin
    assign data_bus = data_oe ? data_out : bus_drv;
    wire chip_sel_n = ser_sel ? m_cs_n : p_cs_n;

    // register core stand-in: read data is a fixed function of address
    assign rd_addr = core_req.rd ? core_req.addr : last_rd_q;
    assign core_rdata = rd_addr[7:0] ^ 8'h3c;
    always @(posedge ref_clk) begin
        if (core_req.rd) begin
            last_rd_q <= core_req.addr;
            rd_cnt++;
        end
        if (core_req.wr) begin
            wr_addr <= core_req.addr;
            wr_data <= core_req.wdata;
            wr_cnt++;
        end
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            print_verdict();
        end
    end

    host_processor_port DUT (.ref_clk(ref_clk), .reset_n(reset_n), .bus_style_select(style),
        .serial_select(ser_sel), .chip_select_n(chip_sel_n), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .direction_n(dir_n), .data_strobe_n(ds_n), .addr(addr),
        .data_in(data_bus), .data_out(data_out), .data_oe(data_oe), .serial_clk(m_sclk),
        .serial_mosi(m_mosi), .serial_miso(miso), .serial_miso_oe(miso_oe),
        .interrupt_n_out(int_out), .interrupt_n_oe(int_oe), .irq_pending(irq),
        .core_req(core_req), .core_rdata(core_rdata));

    serial_master partner (.ref_clk(ref_clk), .cpol(cpol), .cpha(cpha), .miso(miso),
        .miso_oe(miso_oe), .sclk(m_sclk), .mosi(m_mosi), .cs_n(m_cs_n));

    // bit order of a field on the wire
    function automatic logic [13:0] ord(input logic [13:0] v, input int n);
        ord = v;
        if (swap)
            for (int i = 0; i < n; i++) ord[i] = v[n-1-i];
    endfunction

    // one parallel cycle in the current style; sel low keeps select high
    task automatic par_access(input logic sel, input logic wr, input logic [13:0] a,
                              input logic [7:0] d);
        @(negedge ref_clk);
        addr = a;
        bus_drv = wr ? d : ~bus_drv;
        p_cs_n = ~sel;
        rd_n = style | wr;
        wr_n = style | ~wr;
        dir_n = ~wr;
        ds_n = ~style;
        repeat (6) @(negedge ref_clk);
        if (!wr) begin
            `CHK(data_oe, 1'b1)
            `CHK(data_bus, a[7:0] ^ 8'h3c)
        end
        {rd_n, wr_n, ds_n} = 3'b111;
        repeat (2) @(negedge ref_clk);
        p_cs_n = 1'b1;
        repeat (6) @(negedge ref_clk);
    endtask

    // both strobe styles, write then read, plus a write without select
    task automatic par_test();
        int n;
        int r;
        for (int s = 0; s < 2; s++) begin
            style = s[0];
            n = wr_cnt;
            par_access(1'b1, 1'b1, 14'h2a5b ^ 14'(s), 8'hc3 + 8'(s));
            `CHK(wr_cnt, n + 1)
            `CHK(wr_addr, 14'h2a5b ^ 14'(s))
            `CHK(wr_data, 8'hc3 + 8'(s))
            r = rd_cnt;
            par_access(1'b1, 1'b0, 14'h3fff - 14'(s), 8'h00);
            `CHK(data_oe, 1'b0)
            `CHK(rd_cnt, r + 1)
            par_access(1'b0, 1'b1, 14'h0001, 8'h99);
            `CHK(wr_cnt, n + 1)
        end
        $display("done: parallel");
    endtask

    // interrupt pin pulls low only while an interrupt is pending
    task automatic int_test();
        @(negedge ref_clk);
        irq = 1'b1;
        repeat (2) @(negedge ref_clk);
        `CHK(int_oe, 1'b1)
        `CHK(int_out, 1'b0)
        irq = 1'b0;
        repeat (2) @(negedge ref_clk);
        `CHK(int_oe, 1'b0)
        $display("done: interrupt");
    endtask

    // straps on data pins 7..5, set while select is high
    task automatic ser_mode(input logic [2:0] m);
        @(negedge ref_clk);
        ser_sel = 1'b1;
        {cpol, cpha, swap} = m;
        bus_drv = {m, 5'h00};
    endtask

    // control word then one data byte
    task automatic ser_xfer(input logic rw, input logic [13:0] a, input logic b,
                            input logic [7:0] d, output logic [7:0] rx);
        logic [15:0] c;
        logic [13:0] t;
        logic [7:0] junk;
        c = {rw, ord(a, 14), b};
        t = ord({6'h00, d}, 8);
        partner.xfer(c[15:8], junk);
        partner.xfer(c[7:0], junk);
        partner.xfer(t[7:0], rx);
    endtask

    // every clock format and bit order, write then read under one select
    task automatic ser_modes();
        logic [7:0] rx;
        logic [13:0] e;
        int n;
        for (int m = 0; m < 8; m++) begin
            ser_mode(3'(m));
            partner.open_frame();
            n = wr_cnt;
            ser_xfer(1'b0, 14'h1a40 + 14'(m), 1'b0, 8'h5e ^ 8'(m), rx);
            ser_xfer(1'b1, 14'h0281 + 14'(m), 1'b0, 8'h00, rx);
            e = ord({6'h00, 8'h81 + 8'(m) ^ 8'h3c}, 8);
            `CHK(rx, e[7:0])
            `CHK(wr_cnt, n + 1)
            `CHK(wr_addr, 14'h1a40 + 14'(m))
            `CHK(wr_data, 8'h5e ^ 8'(m))
            partner.close_frame();
            `CHK(miso_oe, 1'b0)
        end
        $display("done: serial formats");
    endtask

    // burst read and write, then a select release ends the burst
    task automatic burst_test();
        logic [7:0] rx;
        int n;
        ser_mode(3'b010);
        partner.open_frame();
        ser_xfer(1'b1, 14'h0040, 1'b1, 8'h00, rx);
        `CHK(rx, 8'h40 ^ 8'h3c)
        partner.xfer(8'h00, rx);
        `CHK(rx, 8'h41 ^ 8'h3c)
        partner.close_frame();
        partner.open_frame();
        n = wr_cnt;
        ser_xfer(1'b0, 14'h0ffe, 1'b1, 8'h11, rx);
        partner.xfer(8'h22, rx);
        repeat (8) @(negedge ref_clk);
        `CHK(wr_cnt, n + 2)
        `CHK(wr_addr, 14'h0fff)
        `CHK(wr_data, 8'h22)
        partner.close_frame();
        partner.open_frame();
        ser_xfer(1'b1, 14'h0123, 1'b0, 8'h00, rx);
        `CHK(rx, 8'h23 ^ 8'h3c)
        partner.close_frame();
        $display("done: burst");
    endtask

    task automatic print_verdict();
        $display("counts: compared=%0d mismatched=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (4) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        par_test();
        int_test();
        ser_modes();
        burst_test();
        print_verdict();
    end
endmodule
`default_nettype wire
